// ### logic/csf_pkg.sv
// Purpose: Shared constants and types for the clock select and fanout block.
// Assumes: One system clock; all pins sampled on it.
// Notes: Pin vector positions are shared by the top and its synchroniser.
package csf_pkg;
  localparam int CSF_NUM_OUT = 10;       // Fanout width
  localparam int CSF_SYNC_STAGES = 2;    // Pin synchroniser depth
  localparam int CSF_NUM_PINS = 8;       // Sampled pins
  localparam int CSF_CLK_PERIOD_NS = 5;  // Period of ref_clk
  // Positions inside the sampled pin vector
  localparam int CSF_PIN_A_TRUE = 0;
  localparam int CSF_PIN_A_COMP = 1;
  localparam int CSF_PIN_B_TRUE = 2;
  localparam int CSF_PIN_B_COMP = 3;
  localparam int CSF_PIN_CRYSTAL_SOURCE = 4;
  localparam int CSF_PIN_OE = 5;
  localparam int CSF_PIN_SEL0 = 6;
  localparam int CSF_PIN_SEL1 = 7;
  // Source select codes
  localparam logic [1:0] CSF_SEL_A = 2'h0;
  localparam logic [1:0] CSF_SEL_B = 2'h1;
  localparam int CSF_SEL_CRYSTAL_SOURCE_BIT = 1;
  // Falling edges of the chosen source before the enable state moves
  localparam logic [1:0] CSF_EN_EDGES = 2'h3;
  localparam logic [1:0] CSF_CNT_ZERO = 2'h0;
  localparam logic [1:0] CSF_CNT_ONE = 2'h1;
  typedef enum logic {
    CSF_GATE_OFF = 1'b0,
    CSF_GATE_ON = 1'b1
  } csf_gate_st_t;
endpackage

// ### logic/csf_gate_if.sv
// Purpose: Carries the chosen clock level and enable between top and gate.
// Assumes: All signals are on ref_clk.
// Notes: The top drives level and request; the gate answers with en_act.
`timescale 1ns/1ps
`default_nettype none
interface csf_gate_if;
  logic clk_level; // Chosen source, sampled
  logic en_req;    // Output enable pin, synchronised
  logic en_act;    // Enable state applied to the outputs
  modport gate (input clk_level, input en_req, output en_act);
  modport top (output clk_level, output en_req, input en_act);
endinterface
`default_nettype wire

// ### logic/csf_oe_gate.sv
// Purpose: Moves the output enable only after counted low-going source edges.
// Assumes: Source level is already synchronised and at most a quarter of ref_clk.
// Notes: A source that stands still freezes the enable in its present state.
`timescale 1ns/1ps
`default_nettype none
module csf_oe_gate
  import csf_pkg::*;
(
  input wire logic ref_clk,    // System clock
  input wire logic sys_rst,    // Async reset, high
  csf_gate_if.gate gif         // Level in, enable out
);
  logic prev_r;
  csf_gate_st_t st_r;
  csf_gate_st_t st_nxt;
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  wire logic fall;
  wire logic want;
  wire logic differ;

  // Edge and mismatch decode
  assign fall = prev_r & ~gif.clk_level;
  assign want = gif.en_req;
  assign differ = want != (st_r == CSF_GATE_ON);

  // Count edges only while the request differs; a bounce back restarts it
  assign cnt_nxt = !differ ? CSF_CNT_ZERO : (fall ? cnt_r + CSF_CNT_ONE : cnt_r);
  // Change lands just after a falling edge, so the source is low then
  assign st_nxt = (differ && fall && cnt_nxt == CSF_EN_EDGES) ?
                  (want ? CSF_GATE_ON : CSF_GATE_OFF) : st_r;

  // State registers
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_r <= 1'b0;
      cnt_r <= CSF_CNT_ZERO;
      st_r <= CSF_GATE_OFF;
    end else begin
      prev_r <= gif.clk_level;
      cnt_r <= (st_nxt != st_r) ? CSF_CNT_ZERO : cnt_nxt;
      st_r <= st_nxt;
    end
  end

  assign gif.en_act = (st_r == CSF_GATE_ON);

  a_change_at_low: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $changed(st_r) |-> !$past(gif.clk_level)) else $error("enable moved while source high");
  a_edge_count: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $changed(st_r) |-> $past(cnt_r) == CSF_EN_EDGES - CSF_CNT_ONE && $past(fall)) else $error("enable moved early");
  a_follow_req: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $changed(st_r) |-> (st_r == CSF_GATE_ON) == $past(want)) else $error("enable against request");
endmodule
`default_nettype wire

// ### logic/csf_fanout_top.sv
// Purpose: Clock source select, crystal control and ten-way gated fanout.
// Assumes: All pins are asynchronous and sampled on ref_clk at 200 MHz.
// Notes: Outputs are oversampled copies; pin pulls are modelled off chip.
`timescale 1ns/1ps
`default_nettype none
module csf_fanout_top
  import csf_pkg::*;
#(
  parameter int NUM_OUT = CSF_NUM_OUT
) (
  input wire logic ref_clk,             // System clock
  input wire logic sys_rst,             // Async reset, high
  input wire logic diff_in_a_true,      // Pair A true
  input wire logic diff_in_a_comp,      // Pair A complement
  input wire logic diff_in_b_true,      // Pair B true
  input wire logic diff_in_b_comp,      // Pair B complement
  input wire logic crystal_input,       // Crystal sense
  input wire logic [1:0] src_sel,       // Source select
  input wire logic out_enable,          // Output enable pin
  output logic crystal_drive,           // Crystal feedback drive
  output logic crystal_osc_on,          // Oscillator running
  output logic [NUM_OUT-1:0] clk_out,   // Fanout data
  output logic [NUM_OUT-1:0] clk_out_oe // Fanout drive enables
);
  logic [CSF_NUM_PINS-1:0] sync1_r;
  logic [CSF_NUM_PINS-1:0] sync2_r;
  logic osc_r;
  logic drive_r;
  logic [NUM_OUT-1:0] out_r;
  logic [NUM_OUT-1:0] oe_r;
  wire logic [CSF_NUM_PINS-1:0] pins_raw;
  wire logic [1:0] sel_q;
  wire logic a_level;
  wire logic b_level;
  wire logic x_level;
  wire logic sel_clk;
  wire logic osc_nxt;

  csf_gate_if gif ();

  assign pins_raw = {src_sel[1], src_sel[0], out_enable, crystal_input,
                     diff_in_b_comp, diff_in_b_true, diff_in_a_comp, diff_in_a_true};

  // Two-stage synchronisers; only stage two is read
  genvar gi;
  generate
    for (gi = 0; gi < CSF_NUM_PINS; gi++) begin : g_sync
      always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
        end else begin
          sync1_r[gi] <= pins_raw[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate

  // Pair decode: equal inputs (open or grounded) give low
  assign a_level = sync2_r[CSF_PIN_A_TRUE] & ~sync2_r[CSF_PIN_A_COMP];
  assign b_level = sync2_r[CSF_PIN_B_TRUE] & ~sync2_r[CSF_PIN_B_COMP];
  assign x_level = sync2_r[CSF_PIN_CRYSTAL_SOURCE];
  assign sel_q = {sync2_r[CSF_PIN_SEL1], sync2_r[CSF_PIN_SEL0]};

  // Source mux; reset and a pulled-low select both land on pair A
  assign sel_clk = (sel_q == CSF_SEL_A) ? a_level :
                   (sel_q == CSF_SEL_B) ? b_level : x_level;
  assign osc_nxt = sel_q[CSF_SEL_CRYSTAL_SOURCE_BIT];

  assign gif.clk_level = sel_clk;
  assign gif.en_req = sync2_r[CSF_PIN_OE];

  csf_oe_gate u_gate (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .gif(gif)
  );

  // Oscillator: inverting drive only while the crystal is chosen
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      osc_r <= 1'b0;
      drive_r <= 1'b0;
    end else begin
      osc_r <= osc_nxt;
      drive_r <= osc_nxt & ~x_level;
    end
  end

  // Fanout; data and enable share one gate signal so they move together
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      out_r <= '0;
      oe_r <= '0;
    end else begin
      out_r <= {NUM_OUT{sel_clk & gif.en_act}};
      oe_r <= {NUM_OUT{gif.en_act}};
    end
  end

  assign clk_out = out_r;
  assign clk_out_oe = oe_r;
  assign crystal_osc_on = osc_r;
  assign crystal_drive = drive_r;

  // Checks on routing and fanout
  sequence s_en_pair_a;
    gif.en_act && sel_q == CSF_SEL_A;
  endsequence
  sequence s_en_pair_b;
    gif.en_act && sel_q == CSF_SEL_B;
  endsequence

  a_route_pair_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_en_pair_a |=> clk_out[0] == $past(a_level)) else $error("pair A not routed");
  a_route_pair_b: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_en_pair_b |=> clk_out[0] == $past(b_level)) else $error("pair B not routed");
  a_route_crystal_source: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (gif.en_act && sel_q[CSF_SEL_CRYSTAL_SOURCE_BIT]) |=> clk_out[0] == $past(x_level))
    else $error("crystal not routed");
  a_default_pair: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (sync2_r[CSF_PIN_SEL1:CSF_PIN_SEL0] == CSF_SEL_A) |-> sel_clk == a_level)
    else $error("default source wrong");
  a_osc_off: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !sel_q[CSF_SEL_CRYSTAL_SOURCE_BIT] |=> !crystal_osc_on && !crystal_drive) else $error("oscillator left on");
  a_hiz_disabled: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !gif.en_act |=> clk_out_oe == '0 && clk_out == '0) else $error("output driven while disabled");
  a_pair_high: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (s_en_pair_a and (sync2_r[CSF_PIN_A_TRUE] && !sync2_r[CSF_PIN_A_COMP])) |=> clk_out == '1)
    else $error("pair high not driven high");
  a_pair_low: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (s_en_pair_b and (sync2_r[CSF_PIN_B_TRUE] == sync2_r[CSF_PIN_B_COMP])) |=> clk_out == '0)
    else $error("equal pair not driven low");
  a_fanout_same: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (clk_out == '0 || clk_out == '1) && (clk_out_oe == '0 || clk_out_oe == '1))
    else $error("outputs differ");
  a_oe_delay: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(gif.en_act) |-> $past(gif.en_req, 1) ##1 clk_out_oe == '1) else $error("enable path wrong");
  a_pair_b_high: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (s_en_pair_b and (sync2_r[CSF_PIN_B_TRUE] && !sync2_r[CSF_PIN_B_COMP])) |=> clk_out == '1)
    else $error("pair B high not driven high");
  a_pair_a_low: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (s_en_pair_a and (sync2_r[CSF_PIN_A_TRUE] == sync2_r[CSF_PIN_A_COMP])) |=> clk_out == '0)
    else $error("equal pair A not driven low");

  // Oscillator follows the select; drive is the inverted crystal sense
  a_osc_on_crystal_source: assert property (@(posedge ref_clk) disable iff (sys_rst)
    sel_q[CSF_SEL_CRYSTAL_SOURCE_BIT] |=> crystal_osc_on)
    else $error("oscillator off while crystal chosen");
  a_drive_invert: assert property (@(posedge ref_clk) disable iff (sys_rst)
    sel_q[CSF_SEL_CRYSTAL_SOURCE_BIT] |=> crystal_drive == !$past(x_level))
    else $error("crystal drive not inverted sense");

  // Drive enables and data share one gate, so a disabled output is also low
  a_data_gated: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_out_oe == '0 |-> clk_out == '0) else $error("data while not driven");
  a_oe_tracks: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_out_oe == {NUM_OUT{$past(gif.en_act)}}) else $error("drive enable lags gate");

  // Pins show up two edges late once reset has been gone for two edges
  a_sel_sync: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !$past(sys_rst) && !$past(sys_rst, 2) |-> sel_q == $past(src_sel, 2))
    else $error("select not synchronised");
  a_oe_sync: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !$past(sys_rst) && !$past(sys_rst, 2) |-> gif.en_req == $past(out_enable, 2))
    else $error("enable pin not synchronised");

  // Gate transitions must land between pulses, never across one
  sequence s_gate_opens;
    $rose(gif.en_act);
  endsequence
  sequence s_gate_closes;
    $fell(gif.en_act);
  endsequence
  a_open_clean: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_gate_opens |-> clk_out == '0 ##1 (clk_out_oe == '1 && clk_out == '0))
    else $error("outputs opened mid pulse");
  a_close_clean: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_gate_closes |-> clk_out == '0 ##1 (clk_out_oe == '0 && clk_out == '0))
    else $error("outputs closed mid pulse");

  // Second opinion on the latency, kept apart from the gate's own counter
  // A stopped source leaves the count where it is, so a request can wait forever
  logic chk_prev_r;
  logic [1:0] chk_falls_r;
  wire logic chk_fall;
  wire logic chk_pending;

  assign chk_fall = chk_prev_r & ~sel_clk;
  assign chk_pending = gif.en_req != gif.en_act;

  // Falls seen while a request waits; saturates instead of wrapping
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      chk_prev_r <= 1'b0;
      chk_falls_r <= CSF_CNT_ZERO;
    end else begin
      chk_prev_r <= sel_clk;
      if (!chk_pending) begin
        chk_falls_r <= CSF_CNT_ZERO;
      end else if (chk_fall && chk_falls_r != CSF_EN_EDGES) begin
        chk_falls_r <= chk_falls_r + CSF_CNT_ONE;
      end
    end
  end

  a_third_fall: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $changed(gif.en_act) |-> $past(chk_falls_r) == CSF_EN_EDGES - CSF_CNT_ONE && $past(chk_fall))
    else $error("enable moved before its counted source falls");
endmodule
`default_nettype wire

// ### tb/csf_board_model.sv
// Purpose: Board side model driving the three clock sources.
// Assumes: Sources run far below ref_clk, so oversampling stays clean.
// Notes: An open pair shows both legs low, as the pulls leave it.
`timescale 1ns/1ps
`default_nettype none
module csf_board_model (
  input wire logic ref_clk, // System clock
  input wire logic pair_open, // Float both pairs
  output logic a_true, // Pair A true
  output logic a_comp, // Pair A complement
  output logic b_true, // Pair B true
  output logic b_comp, // Pair B complement
  output logic crystal_source // Crystal level
);
  logic [4:0] cnt_r = 5'h00;
  // Free counter gives three distinct source rates
  always @(posedge ref_clk) begin
    cnt_r <= cnt_r + 5'h01;
  end
  // Pair A period 8, pair B 16, crystal 32 ref cycles
  assign a_true = pair_open ? 1'b0 : cnt_r[2];
  assign a_comp = pair_open ? 1'b0 : ~cnt_r[2];
  assign b_true = pair_open ? 1'b0 : cnt_r[3];
  assign b_comp = pair_open ? 1'b0 : ~cnt_r[3];
  assign crystal_source = cnt_r[4];
endmodule
`default_nettype wire

// ### tb/tb_clock_select_fanout_enable.sv
// Purpose: Self-checking bench for the clock select and fanout block.
// Assumes: Bench pins change by non-blocking assignment 1 ns after the rising edge; board pins change on it.
// Notes: Expected output level comes from a three-edge pipe of the pins.
`timescale 1ns/1ps
`default_nettype none
module tb_clock_select_fanout_enable;
  import csf_pkg::*;
  localparam logic [CSF_NUM_OUT-1:0] ALL1 = '1;
  localparam int SRC_A_PERIOD = 8; // Pair A period in ref cycles, from the board model
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [1:0] src_sel = 2'h0;
  logic out_enable = 1'b0;
  logic pair_open = 1'b0;
  logic a_t, a_c, b_t, b_c, crystal_source, xdrive, osc_on;
  logic [CSF_NUM_OUT-1:0] clk_out, clk_out_oe;
  logic [2:0] exp_pipe_r = 3'h0;
  int fails = 0;
  int samples_checked = 0;
  wire logic src_now = src_sel[1] ? crystal_source : (src_sel[0] ? (b_t & ~b_c) : (a_t & ~a_c));
  always #2.5 ref_clk = ~ref_clk;
  // Reference pipe: pin level reaches clk_out three edges later
  always @(posedge ref_clk) exp_pipe_r <= {exp_pipe_r[1:0], src_now};
  csf_board_model board (.ref_clk(ref_clk), .pair_open(pair_open), .a_true(a_t), .a_comp(a_c),
    .b_true(b_t), .b_comp(b_c), .crystal_source(crystal_source));
  csf_fanout_top dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .diff_in_a_true(a_t), .diff_in_a_comp(a_c),
    .diff_in_b_true(b_t), .diff_in_b_comp(b_c), .crystal_input(crystal_source), .src_sel(src_sel),
    .out_enable(out_enable), .crystal_drive(xdrive), .crystal_osc_on(osc_on), .clk_out(clk_out),
    .clk_out_oe(clk_out_oe));
  task automatic check(input string what, input logic [CSF_NUM_OUT-1:0] exp, input logic [CSF_NUM_OUT-1:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask
  // Waits for the drive enables to reach a value; returns cycles taken
  task automatic wait_oe(input logic [CSF_NUM_OUT-1:0] target, output int n);
    n = 0;
    while (clk_out_oe !== target && n < 60) begin
      tick();
      n++;
    end
  endtask
  task automatic t_oe_off();
    for (int s = 0; s < 4; s++) begin
      src_sel <= s[1:0];
      repeat (12) begin
        tick();
        check("oe while disabled", '0, clk_out_oe);
      end
    end
  endtask
  task automatic t_short_pulse();
    out_enable <= 1'b1;
    tick();
    tick();
    out_enable <= 1'b0;
    repeat (40) begin
      tick();
      check("oe after short pulse", '0, clk_out_oe);
    end
  endtask
  task automatic t_enable(input logic on);
    int n;
    src_sel <= CSF_SEL_A;
    tick();
    out_enable <= on;
    wait_oe(on ? ALL1 : '0, n);
    check("enable delay in range", ALL1, (n >= 2 * SRC_A_PERIOD && n <= 3 * SRC_A_PERIOD + 4) ? ALL1 : '0);
    check("level at enable change", '0, clk_out);
  endtask
  task automatic t_fanout();
    for (int i = 0; i < 6; i++) begin
      src_sel <= i[1:0];
      pair_open <= (i >= 4);
      repeat (4) tick();
      repeat (40) begin
        tick();
        check("fanout level", {CSF_NUM_OUT{exp_pipe_r[2]}}, clk_out);
        check("oscillator on", {9'h000, src_sel[1]}, {9'h000, osc_on});
        check("crystal drive", {9'h000, src_sel[1] & ~exp_pipe_r[2]}, {9'h000, xdrive});
      end
    end
    pair_open <= 1'b0;
  endtask
  task automatic t_reset_mid();
    int n;
    sys_rst <= 1'b1;
    tick();
    check("oe in reset", '0, clk_out_oe);
    sys_rst <= 1'b0;
    tick();
    check("oe after reset release", '0, clk_out_oe);
    wait_oe(ALL1, n);
    check("delay after reset", ALL1, (n >= 2 * SRC_A_PERIOD && n <= 3 * SRC_A_PERIOD + 4) ? ALL1 : '0);
    check("level at enable change", '0, clk_out);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Watchdog well past the few hundred cycles the tests need
  initial begin
    #100000;
    fails++;
    give_verdict();
  end
  // Main sequence
  initial begin
    repeat (6) tick();
    check("oe in reset", '0, clk_out_oe);
    sys_rst <= 1'b0;
    tick();
    t_oe_off();
    t_short_pulse();
    t_enable(1'b1);
    t_fanout();
    t_enable(1'b0);
    t_enable(1'b1);
    t_reset_mid();
    give_verdict();
  end
endmodule
`default_nettype wire
